// >>> rtl/frg_ramp.sv
// Purpose: Frequency reference ramp generator with two dynamics sets
// Assumes: Command inputs synchronous to clk_i; start, stop, reverse are pulses
// Notes: Reference in signed 0.01 Hz counts; negative is reverse rotation
//
// How it works
// - Two acceleration times, 0 to 50 Hz
// - Two deceleration times, 50 Hz to 0
// - After start, ramp up at acceleration rate
// - Reverse decelerates to zero, then accelerates opposite
// - Nonzero stop time sets stop deceleration
// - Zero stop time uses active deceleration
// - S-curve rounds ramp start and end
// - Selection fixes set one or set two
// - Selection may follow a digital input
// - No restart before minimum halt time
// - Start-up delay before reference ramps
// - Start-up delay counted in 0.1 s units
`include "frg_defines.svh"
`default_nettype none
module frg_ramp import frg_pkg::*; #(
   parameter int unsigned TICK_CYC = `FRG_TICK_CYC,  // Clocks per 1 ms ramp tick
   parameter int unsigned FW = `FRG_FW,              // Set-point width
   parameter int unsigned TW = `FRG_TW               // Time setting width
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,                 // Start command pulse
   input wire logic stop_i,                  // Stop command pulse
   input wire logic reverse_i,               // Reverse command pulse
   input wire logic [FW-1:0] setpoint_i,     // Target magnitude, 0.01 Hz
   input wire logic [TW-1:0] accel_one_i,    // Set one acceleration, 0.1 s
   input wire logic [TW-1:0] decel_one_i,    // Set one deceleration, 0.1 s
   input wire logic [TW-1:0] accel_two_i,    // Set two acceleration, 0.1 s
   input wire logic [TW-1:0] decel_two_i,    // Set two deceleration, 0.1 s
   input wire logic [TW-1:0] stop_time_i,    // Stop deceleration, 0 is off
   input wire logic [3:0] scurve_i,          // S-curve strength, 0 is off
   input wire logic [1:0] dyn_mode_i,        // Dynamics selection mode
   input wire logic dyn_din_i,               // Digital input choosing set two
   input wire logic [TW-1:0] min_halt_i,     // Minimum halt time, 0.1 s
   input wire logic [TW-1:0] start_delay_i,  // Start-up delay, 0.1 s
   output logic signed [FW:0] freq_ref_o,    // Smoothed frequency reference
   output logic halted_o,                    // Halted state
   output logic running_o,                   // Run state
   output logic stopping_o,                  // Stopping ramp in progress
   output logic set_two_o                    // Set two in use
);
   localparam int unsigned DW = $clog2(TICK_CYC);  // Tick divider width

   frg_state_e state_r;             // Controller state
   logic [DW-1:0] div_r;            // Tick divider
   logic tick_r;                    // 1 ms pulse
   logic [6:0] tenth_r;             // Ticks within 0.1 s
   logic tenth_en;                  // 0.1 s pulse
   logic run_r;                     // Run command latched
   logic dir_r;                     // Reverse rotation wanted
   logic [TW-1:0] cnt_r;            // Halt or delay count, 0.1 s
   logic signed [FW:0] ref_r;       // Linear ramp reference
   logic [23:0] acc_r;              // Rate accumulator, counts times ms
   logic signed [FW:0] target;      // Where the ramp heads
   logic use_two;                   // Set two active
   logic toward_zero;               // Ramp is decelerating
   logic [TW-1:0] t_ds;             // Applicable ramp time, 0.1 s
   logic [23:0] t_ms;               // Applicable ramp time, ms
   logic [23:0] acc_sum;            // Accumulator after this tick

   // Ramp tick and 0.1 s enable; one clock, no derived clocks
   always_ff @(posedge clk_i) begin
      if (rst_i || div_r == DW'(TICK_CYC - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + DW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      tick_r <= !rst_i && div_r == DW'(TICK_CYC - 1);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tenth_r <= '0;
      end else if (tick_r) begin
         tenth_r <= (tenth_r == 7'(`FRG_TICKS_PER_TENTH - 1)) ? 7'h00 : tenth_r + 7'h01;
      end
   end
   assign tenth_en = tick_r && tenth_r == 7'(`FRG_TICKS_PER_TENTH - 1);

   // Command latch; stop wins over a start in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_r <= 1'b0;
      end else if (stop_i) begin
         run_r <= 1'b0;
      end else if (start_i) begin
         run_r <= 1'b1;
      end
   end

   // Reverse flips the target sign; the ramp passes through zero on its own
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_r <= 1'b0;
      end else if (reverse_i) begin
         dir_r <= !dir_r;
      end
   end

   // Rate selection, re-evaluated every cycle so changes apply mid-ramp
   always_comb begin
      case (dyn_mode_i)
         FRG_DYN_TWO: use_two = 1'b1;
         FRG_DYN_INPUT: use_two = dyn_din_i;
         default: use_two = 1'b0;
      endcase
      if (state_r == FRG_RUN) begin
         target = dir_r ? -$signed({1'b0, setpoint_i}) : $signed({1'b0, setpoint_i});
      end else begin
         target = '0;
      end
      // Heading toward zero, or across it, counts as deceleration
      toward_zero = (ref_r > 0 && target < ref_r) || (ref_r < 0 && target > ref_r);
      if (!toward_zero) begin
         t_ds = use_two ? accel_two_i : accel_one_i;
      end else if (state_r == FRG_STOP && stop_time_i != '0) begin
         t_ds = stop_time_i;
      end else begin
         t_ds = use_two ? decel_two_i : decel_one_i;
      end
      t_ms = 24'(t_ds) * `FRG_MS_PER_TENTH;
      if (t_ms == '0) begin
         t_ms = 24'h000001;  // Zero time means fastest ramp
      end
      acc_sum = acc_r + (tick_r ? `FRG_FULL_SCALE : 24'h000000);
   end

   // Linear ramp: each tick adds 50 Hz worth of credit, one count per t_ms credit.
   // Several counts may follow one tick; at most one per clock, so the fastest
   // ramp (zero time, t_ms of 1) never saturates. Credit is dropped at the target.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_r <= '0;
         ref_r <= '0;
      end else if (ref_r == target) begin
         acc_r <= '0;
      end else if (acc_sum >= t_ms) begin
         acc_r <= acc_sum - t_ms;
         ref_r <= (ref_r < target) ? ref_r + (FW+1)'(1) : ref_r - (FW+1)'(1);
      end else begin
         acc_r <= acc_sum;
      end
   end

   // Sequencer: halt hold, start-up delay, run, stop ramp
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= FRG_HALT;
         cnt_r <= '0;
      end else begin
         case (state_r)
            FRG_HALT: begin
               if (tenth_en && cnt_r != '0) begin
                  cnt_r <= cnt_r - TW'(1);
               end
               if (run_r && cnt_r == '0) begin
                  state_r <= FRG_DELAY;
                  cnt_r <= start_delay_i;
               end
            end
            FRG_DELAY: begin
               if (!run_r) begin
                  state_r <= FRG_HALT;
                  cnt_r <= '0;  // Motor never turned, so no leftover delay becomes a halt hold
               end else if (cnt_r == '0) begin
                  state_r <= FRG_RUN;
               end else if (tenth_en) begin
                  cnt_r <= cnt_r - TW'(1);
               end
            end
            FRG_RUN: begin
               if (!run_r) begin
                  state_r <= FRG_STOP;
               end
            end
            FRG_STOP: begin
               if (ref_r == '0) begin
                  state_r <= FRG_HALT;
                  cnt_r <= min_halt_i;
               end
            end
            default: begin
               state_r <= FRG_HALT;  // Recover from an illegal code
               cnt_r <= '0;
            end
         endcase
      end
   end

   // Status flags, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halted_o <= 1'b1;
         running_o <= 1'b0;
         stopping_o <= 1'b0;
         set_two_o <= 1'b0;
      end else begin
         halted_o <= state_r == FRG_HALT;
         running_o <= state_r == FRG_RUN;
         stopping_o <= state_r == FRG_STOP;
         set_two_o <= use_two;
      end
   end

   // S-curve rounding of the linear ramp
   frg_smooth #(.W(FW + 1)) u_smooth (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_r),
      .shift_i(scurve_i),
      .in_i(ref_r),
      .out_o(freq_ref_o)
   );

   // Checks on the ramp and sequencer
   property p_step_one;
      @(posedge clk_i) disable iff (rst_i)
      !$stable(ref_r) |-> (ref_r - $past(ref_r) == 1 || $past(ref_r) - ref_r == 1);
   endproperty
   a_step_one: assert property (p_step_one) else $error("Reference moved more than one count");

   property p_hold_target;
      @(posedge clk_i) disable iff (rst_i)
      (ref_r == target && $stable(target)) |=> ref_r == $past(ref_r);
   endproperty
   a_hold_target: assert property (p_hold_target) else $error("Reference left its target");

   property p_zero_idle;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == FRG_DELAY) |-> ref_r == 0;
   endproperty
   a_zero_idle: assert property (p_zero_idle) else $error("Reference moved during start-up delay");

   property p_halt_hold;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == FRG_HALT && cnt_r != 0) |=> state_r != FRG_DELAY;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("Restart before minimum halt time");

   property p_stop_time;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == FRG_STOP && ref_r != 0 && stop_time_i != 0) |-> t_ms == 24'(stop_time_i) * 24'd100;
   endproperty
   a_stop_time: assert property (p_stop_time) else $error("Stop ramp not using stop time");

   property p_stop_fall;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == FRG_STOP && $past(state_r) == FRG_STOP) |-> (ref_r >= 0 ? ref_r : -ref_r) <=
         ($past(ref_r) >= 0 ? $past(ref_r) : -$past(ref_r));
   endproperty
   a_stop_fall: assert property (p_stop_fall) else $error("Magnitude grew while stopping");

   property p_fixed_set;
      @(posedge clk_i) disable iff (rst_i)
      (dyn_mode_i == FRG_DYN_ONE) [*2] |-> !set_two_o;
   endproperty
   a_fixed_set: assert property (p_fixed_set) else $error("Set two used while set one fixed");

   property p_din_set;
      @(posedge clk_i) disable iff (rst_i)
      (dyn_mode_i == FRG_DYN_INPUT && dyn_din_i) |=> set_two_o;
   endproperty
   a_din_set: assert property (p_din_set) else $error("Digital input did not pick set two");

   property p_run_accel;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == FRG_RUN && ref_r >= 0 && target > ref_r && !use_two) |-> t_ds == accel_one_i;
   endproperty
   a_run_accel: assert property (p_run_accel) else $error("Acceleration time not applied");

   property p_delay_to_run;
      @(posedge clk_i) disable iff (rst_i)
      (state_r == FRG_DELAY && run_r && cnt_r == 0) |=> state_r == FRG_RUN;
   endproperty
   a_delay_to_run: assert property (p_delay_to_run) else $error("Delay end did not start ramp");
endmodule : frg_ramp
`default_nettype wire

// >>> rtl/frg_defines.svh
// Purpose: Timing counts and setting widths of the ramp generator
// Assumes: 50 MHz system clock
// Notes: Frequencies in 0.01 Hz units, settings times in 0.1 s units
`ifndef FRG_DEFINES_SVH
`define FRG_DEFINES_SVH

`define FRG_CLK_NS 20                               // Clock period in ns
`define FRG_TICK_NS 1000000                         // Ramp tick period in ns (1 ms)
`define FRG_TICK_CYC (`FRG_TICK_NS / `FRG_CLK_NS)    // Clocks per ramp tick
`define FRG_TICKS_PER_TENTH 100                     // Ramp ticks per 0.1 s
`define FRG_MS_PER_TENTH 24'h000064                 // Milliseconds in one 0.1 s unit
`define FRG_FULL_SCALE 24'h001388                   // 50 Hz in 0.01 Hz units (5000)
`define FRG_FW 16                                   // Width of frequency settings
`define FRG_TW 16                                   // Width of time settings

`endif

// >>> rtl/frg_pkg.sv
// Purpose: Types shared by the frequency ramp generator
// Assumes: Nothing beyond the defines header
// Notes: States are one-hot
`default_nettype none
package frg_pkg;
   // Controller states, one-hot
   typedef enum logic [4:0] {
      FRG_HALT  = 5'h01,   // Reference zero, minimum halt time running
      FRG_DELAY = 5'h02,   // Start-up delay before ramping
      FRG_RUN   = 5'h04,   // Ramping toward set-point
      FRG_STOP  = 5'h08,   // Ramping down to zero
      FRG_SPARE = 5'h10    // Unused, recovers to halt
   } frg_state_e;

   // Dynamics selection modes
   typedef enum logic [1:0] {
      FRG_DYN_ONE   = 2'h0,  // Fixed set one
      FRG_DYN_TWO   = 2'h1,  // Fixed set two
      FRG_DYN_INPUT = 2'h2,  // Chosen by digital input
      FRG_DYN_RSVD  = 2'h3   // Treated as set one
   } frg_dyn_e;
endpackage : frg_pkg
`default_nettype wire

// >>> rtl/frg_smooth.sv
// Purpose: S-curve rounding of the linear ramp by a first-order lag
// Assumes: tick_i is a one-cycle pulse
// Notes: shift_i of zero passes the ramp straight through
`default_nettype none
module frg_smooth #(
   parameter int unsigned W = 17  // Signed reference width
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,            // Ramp tick
   input wire logic [3:0] shift_i,     // Lag strength, 0 is off
   input wire logic signed [W-1:0] in_i,
   output logic signed [W-1:0] out_o
);
   logic signed [W-1:0] diff;  // Remaining distance
   logic signed [W-1:0] delta; // Step for this tick

   // Step is a fraction of the distance, at least one count so it lands exactly
   always_comb begin
      diff = in_i - out_o;
      delta = diff >>> shift_i;
      if (delta == '0 && diff != '0) begin
         delta = (diff < 0) ? -W'(1) : W'(1);
      end
   end

   // Lag follows the linear ramp; slope builds and fades gradually
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_o <= '0;
      end else if (shift_i == 4'h0) begin
         out_o <= in_i;
      end else if (tick_i) begin
         out_o <= out_o + delta;
      end
   end
endmodule : frg_smooth
`default_nettype wire

// >>> verif/frg_drive_model.sv
// Purpose: Modulation stage model that takes the frequency reference
// Assumes: One clock, synchronous reset
// Notes: Counts reference steps above one count per clock
`default_nettype none
module frg_drive_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic lin_i,                    // Linear ramp expected
   input wire logic signed [16:0] freq_ref_i, // Reference from the ramp block
   output int jumps_o                         // Steps that were too large
);
   timeunit 1ns;
   timeprecision 1ps;
   logic signed [16:0] last_r; // Reference one clock ago
   // A jump would shake the motor, so any step above one count is counted while lin_i is set
   always_ff @(posedge clk_i) begin
      last_r <= freq_ref_i;
      if (rst_i) jumps_o <= 0;
      else if (lin_i && (freq_ref_i - last_r > 1 || last_r - freq_ref_i > 1)) jumps_o <= jumps_o + 1;
   end
endmodule : frg_drive_model
`default_nettype wire

// >>> verif/frg_ramp_tb.sv
// Purpose: Self-checking bench of the frequency ramp generator
// Assumes: Short tick of five clocks, so 0.1 s is 500 clocks
// Notes: Ramp times are checked in windows, the tick phase is free-running
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_total++; $display("Error %s expected %0d seen %0d", nm, ex, gt); end end
module frg_ramp_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 5; // Clocks per tick, kept small for run length
   logic clk_i, rst_i, start_i, stop_i, reverse_i, dyn_din_i, lin;
   logic [15:0] setpoint_i, accel_one_i, decel_one_i, accel_two_i, decel_two_i, stop_time_i, min_halt_i, start_delay_i;
   logic [3:0] scurve_i;
   logic [1:0] dyn_mode_i;
   logic signed [16:0] freq_ref_o;
   logic halted_o, running_o, stopping_o, set_two_o;
   int err_total, n_checks, cyc, jumps, c;
   frg_ramp #(.TICK_CYC(TC)) u_dut (.clk_i, .rst_i, .start_i, .stop_i, .reverse_i, .setpoint_i, .accel_one_i,
      .decel_one_i, .accel_two_i, .decel_two_i, .stop_time_i, .scurve_i, .dyn_mode_i, .dyn_din_i, .min_halt_i,
      .start_delay_i, .freq_ref_o, .halted_o, .running_o, .stopping_o, .set_two_o);
   frg_drive_model u_model (.clk_i, .rst_i, .lin_i(lin), .freq_ref_i(freq_ref_o), .jumps_o(jumps));
   // Free-running 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Hang guard, well above the expected run
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // One command pulse, 0 start, 1 stop, 2 reverse
   task automatic cmd(input int k);
      @(posedge clk_i);
      case (k)
         0: start_i <= 1'b1;
         1: stop_i <= 1'b1;
         default: reverse_i <= 1'b1;
      endcase
      @(posedge clk_i);
      start_i <= 1'b0;
      stop_i <= 1'b0;
      reverse_i <= 1'b0;
   endtask : cmd
   // Clocks until the reference lands on a value, sampled off the edge only
   task automatic wait_ref(input logic signed [16:0] tgt, output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (freq_ref_o !== tgt && n < 8000);
   endtask : wait_ref
   task automatic go(input int k, input logic signed [16:0] tgt, output int n);
      cmd(k);
      wait_ref(tgt, n);
   endtask : go
   task automatic wait_run(output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (running_o !== 1'b1 && n < 8000);
   endtask : wait_run
   // Linear ramp time in clocks: counts times 0.1 s units at 50 Hz full scale
   function automatic int rc(input int t01, input int cnt);
      return cnt * t01 * TC / 50;
   endfunction : rc
   function automatic logic inw(input int n, input int e);
      return n >= e - 2 * TC && n <= e + 4 * TC + 10;
   endfunction : inw
   task automatic t_reset();
      `CHK("reference", 17'sh0, freq_ref_o)
      `CHK("halted", 1'b1, halted_o)
      `CHK("set two", 1'b0, set_two_o)
   endtask : t_reset
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         for (int d = 0; d < 2; d++) begin
            @(posedge clk_i);
            dyn_mode_i <= 2'(m);
            dyn_din_i <= 1'(d);
            repeat (3) @(negedge clk_i);
            `CHK("set two", (m == 1 || (m == 2 && d == 1)), set_two_o)
         end
      end
      @(posedge clk_i);
      dyn_mode_i <= 2'h0;
   endtask : t_modes
   task automatic t_accel_stop();
      go(0, 17'sd500, c);
      `CHK("accel time", 1'b1, inw(c, rc(10, 500)))
      repeat (30) @(negedge clk_i);
      `CHK("held target", 17'sd500, freq_ref_o)
      go(1, 17'sd0, c);
      `CHK("stop decel", 1'b1, inw(c, rc(10, 500)))
      repeat (4) @(negedge clk_i);
      `CHK("halted after stop", 1'b1, halted_o)
      `CHK("not stopping", 1'b0, stopping_o)
   endtask : t_accel_stop
   task automatic t_stop_time();
      go(0, 17'sd500, c);
      @(posedge clk_i);
      stop_time_i <= 16'h0014;
      cmd(1);
      repeat (10) @(negedge clk_i);
      `CHK("stopping", 1'b1, stopping_o)
      wait_ref(17'sd0, c);
      `CHK("stop time", 1'b1, inw(c + 10, rc(20, 500)))
      @(posedge clk_i);
      stop_time_i <= 16'h0000;
   endtask : t_stop_time
   task automatic t_halt_delay();
      @(posedge clk_i);
      min_halt_i <= 16'h0002;
      go(0, 17'sd500, c);
      go(1, 17'sd0, c);
      @(posedge clk_i);
      min_halt_i <= 16'h0000;
      cmd(0);
      wait_run(c);
      `CHK("min halt", 1'b1, (c >= 500 - 2 * TC && c <= 1000 + 30))
      // Let the ramp leave zero, or the stop wait would end at once
      repeat (20) @(negedge clk_i);
      go(1, 17'sd0, c);
      @(posedge clk_i);
      start_delay_i <= 16'h0002;
      cmd(0);
      wait_run(c);
      `CHK("start delay", 1'b1, (c >= 500 - 2 * TC && c <= 1000 + 30))
      `CHK("ref still", 17'sh0, freq_ref_o)
      repeat (20) @(negedge clk_i);
      @(posedge clk_i);
      start_delay_i <= 16'h0000;
      go(1, 17'sd0, c);
   endtask : t_halt_delay
   task automatic t_set_two();
      @(posedge clk_i);
      dyn_mode_i <= 2'h1;
      go(0, 17'sd500, c);
      `CHK("accel two", 1'b1, inw(c, rc(20, 500)))
      go(1, 17'sd0, c);
      `CHK("decel two", 1'b1, inw(c, rc(30, 500)))
      // Switch sets about 100 counts into the ramp; the rest goes at set two rate
      @(posedge clk_i);
      dyn_mode_i <= 2'h0;
      cmd(0);
      repeat (100) @(negedge clk_i);
      @(posedge clk_i);
      dyn_mode_i <= 2'h1;
      wait_ref(17'sd500, c);
      `CHK("mid-ramp switch", 1'b1, inw(c, rc(20, 400)))
      `CHK("set two live", 1'b1, set_two_o)
      go(1, 17'sd0, c);
      @(posedge clk_i);
      dyn_mode_i <= 2'h0;
   endtask : t_set_two
   task automatic t_scurve();
      @(posedge clk_i);
      lin <= 1'b0;
      scurve_i <= 4'h3;
      go(0, 17'sd500, c);
      `CHK("rounded slower", 1'b1, (c > rc(10, 500) && c < 8000))
      repeat (20) @(negedge clk_i);
      `CHK("rounded end", 17'sd500, freq_ref_o)
      @(posedge clk_i);
      scurve_i <= 4'h0;
      repeat (20) @(negedge clk_i);
      lin <= 1'b1;
      go(2, -17'sd500, c);
      `CHK("reverse", 1'b1, inw(c, rc(10, 1000)))
      go(1, 17'sd0, c);
      `CHK("no jumps", 0, jumps)
   endtask : t_scurve
   // Main sequence
   initial begin
      {start_i, stop_i, reverse_i, dyn_din_i, scurve_i, dyn_mode_i} = '0;
      {stop_time_i, min_halt_i, start_delay_i} = '0;
      setpoint_i = 16'h01f4;
      accel_one_i = 16'h000a;
      decel_one_i = 16'h000a;
      accel_two_i = 16'h0014;
      decel_two_i = 16'h001e;
      lin = 1'b1;
      rst_i = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      t_reset();
      t_modes();
      t_accel_stop();
      t_stop_time();
      t_halt_delay();
      t_set_two();
      t_scurve();
      report_and_stop();
   end
endmodule : frg_ramp_tb
`default_nettype wire
